// ### shared/dect_defs.vh
// register map, field layout, reset values and timing for the dual
// event counter/timer; assumes the includer runs on one 250 MHz clock.
`ifndef DECT_DEFS_VH
`define DECT_DEFS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define DECT_ADDR_W 8
`define DECT_A_UNIT_SEL 8'h00
`define DECT_A_COUNT_SRC 8'h04
`define DECT_A_TRIG_SRC 8'h08
`define DECT_A_CLEAR_SRC 8'h0C
`define DECT_A_DELAY 8'h10
`define DECT_A_DURATION 8'h14
`define DECT_A_LIVE 8'h18
`define DECT_A_CAPTURED 8'h1C
`define DECT_A_STATE 8'h20
`define DECT_A_IRQ_STAT 8'h24
`define DECT_A_IRQ_MASK 8'h28

// ----------------------------------------------------------------------
// fields and widths
// ----------------------------------------------------------------------
`define DECT_CNT_W 32
`define DECT_SRC_LSB 0
`define DECT_SRC_MSB 4
`define DECT_QUAL_LSB 8
`define DECT_QUAL_MSB 10
`define DECT_IRQ_W 6
`define DECT_IRQ_WRAP_LSB 4

// source codes; the source vector bit index equals the code
`define DECT_SRC_OFF 5'h00
`define DECT_SRC_TICK 5'h01
// codes 02-05 line inputs, 06-09 soft outputs, 0A-0B unit begin,
// 0C-0D unit finish, 0E-0F lut cells, 10 open, 11 close, 12 arm wait
`define DECT_PULSE_MASK 32'h0003_3C02

// qualification codes
`define DECT_QUALIFY_LOW 3'h0
`define DECT_QUALIFY_HIGH 3'h1
`define DECT_QUALIFY_FALL 3'h2
`define DECT_QUALIFY_RISE 3'h3
`define DECT_QUALIFY_BOTH 3'h4

// unit state codes as read back
`define DECT_ST_IDLE 3'h0
`define DECT_ST_ARMED 3'h1
`define DECT_ST_RUNNING 3'h2
`define DECT_ST_DONE 3'h3
`define DECT_ST_WRAPPED 3'h4

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define DECT_QUAL_RST 3'h3
`define DECT_DELAY_RST 32'h0000_0001
`define DECT_DURATION_RST 32'h0000_0001
`define DECT_CLK_NS 4
`define DECT_TICK_NS 1000
`define DECT_TICK_CYCLES (`DECT_TICK_NS / `DECT_CLK_NS)

`endif

// ### rtl/dect_top.v
// two event counter/timer units with a plain register port and interrupt.
// assumes all signal inputs are synchronous to clk_in and that the
// register master never asserts both strobes in one cycle.
`timescale 1ns/10ps
`include "dect_defs.vh"

// Contract
// - two counter units 0 and 1; a select register picks which one
// - each unit counts hits of its chosen source; source off stops it
// - sources: tick, lines, soft outputs, unit events, lut, shutter, arm
// - count source qualified by low, high, fall, rise or both edges
// - begin event when the count reaches the start delay value
// - finish event when the count reaches the end duration value
// - trigger source and clear source exclusive; setting one drops other
// - unit starts counting when its trigger source fires
// - trigger qualified by low, high, fall, rise or both edges
// - unit ends and resets its count when its clear source fires
// - clear qualified by low, high, fall, rise or both edges
// - live count of the selected unit is readable, read only
// - count before a clear is captured; software may also write it
// - read-only state of the selected unit reflects its operation
// - state is idle, armed, running, done or wrapped
module dect_top (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [3:0] line_in,
    input wire [3:0] soft_output_in,
    input wire [1:0] lut_cell_out_in,
    input wire shutter_open_event_in,
    input wire shutter_close_event_in,
    input wire frame_arm_wait_in,
    output wire [31:0] rdata_out,
    output wire irq_out,
    output wire [1:0] unit_begin_event_out,
    output wire [1:0] unit_finish_event_out
);

    // one-hot unit states
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_ARMED = 5'b00010;
    localparam [4:0] S_RUNNING = 5'b00100;
    localparam [4:0] S_DONE = 5'b01000;
    localparam [4:0] S_WRAPPED = 5'b10000;
    localparam [31:0] TICK_LAST = `DECT_TICK_CYCLES - 1;
    localparam [31:0] CNT_MAX = 32'hFFFF_FFFF;
    localparam [31:0] PULSE_MASK = `DECT_PULSE_MASK;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // pulse sources are taken as they are; levels go through the mode
    function qualify;
        input cur;
        input prev;
        input [2:0] mode;
        input pulse;
        begin
            if (pulse) begin
                qualify = cur;
            end else begin
                case (mode)
                    `DECT_QUALIFY_LOW: qualify = ~cur;
                    `DECT_QUALIFY_HIGH: qualify = cur;
                    `DECT_QUALIFY_FALL: qualify = prev & ~cur;
                    `DECT_QUALIFY_RISE: qualify = ~prev & cur;
                    `DECT_QUALIFY_BOTH: qualify = prev ^ cur;
                    default: qualify = 1'b0;
                endcase
            end
        end
    endfunction

    function [2:0] state_code;
        input [4:0] st;
        begin
            case (st)
                S_ARMED: state_code = `DECT_ST_ARMED;
                S_RUNNING: state_code = `DECT_ST_RUNNING;
                S_DONE: state_code = `DECT_ST_DONE;
                S_WRAPPED: state_code = `DECT_ST_WRAPPED;
                default: state_code = `DECT_ST_IDLE;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // microsecond tick divider
    // ------------------------------------------------------------------
    reg [7:0] tick_cnt_reg;
    reg tick_reg;

    // one-cycle enable every microsecond
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST[7:0]) begin
            tick_cnt_reg <= 8'h00;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // shared source vector
    // ------------------------------------------------------------------
    reg unit_sel_reg;
    wire [1:0] begin_w;
    wire [1:0] finish_w;
    wire [31:0] src_vec;
    reg [31:0] src_prev_reg;

    // bit index is the source code; code 0 (off) is always low
    assign src_vec = {13'h0000, frame_arm_wait_in, shutter_close_event_in,
                      shutter_open_event_in, lut_cell_out_in, finish_w,
                      begin_w, soft_output_in, line_in, tick_reg,
                      1'b0};

    // previous sample feeds every edge qualifier
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            src_prev_reg <= 32'h0000_0000;
        end else begin
            src_prev_reg <= src_vec;
        end
    end

    // decoded strobes, shared by all units
    wire wr_count_src = wr_en_in && (addr_in == `DECT_A_COUNT_SRC);
    wire wr_trig_src = wr_en_in && (addr_in == `DECT_A_TRIG_SRC);
    wire wr_clear_src = wr_en_in && (addr_in == `DECT_A_CLEAR_SRC);
    wire wr_delay = wr_en_in && (addr_in == `DECT_A_DELAY);
    wire wr_duration = wr_en_in && (addr_in == `DECT_A_DURATION);
    wire wr_captured = wr_en_in && (addr_in == `DECT_A_CAPTURED);
    wire [4:0] wsrc = wdata_in[`DECT_SRC_MSB:`DECT_SRC_LSB];
    wire [2:0] wqual = wdata_in[`DECT_QUAL_MSB:`DECT_QUAL_LSB];

    wire [31:0] live_w [0:1];
    wire [31:0] capt_w [0:1];
    wire [31:0] delay_w [0:1];
    wire [31:0] dur_w [0:1];
    wire [10:0] csrc_w [0:1];
    wire [10:0] tsrc_w [0:1];
    wire [10:0] rsrc_w [0:1];
    wire [2:0] st_w [0:1];
    wire [5:0] ev_set;

    // ------------------------------------------------------------------
    // counter units
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : unit
            localparam [31:0] IDX = gi;
            wire mine = (unit_sel_reg == IDX[0]);
            reg [4:0] cnt_src_reg;
            reg [2:0] cnt_qual_reg;
            reg [4:0] trig_src_reg;
            reg [2:0] trig_qual_reg;
            reg [4:0] clr_src_reg;
            reg [2:0] clr_qual_reg;
            reg [31:0] delay_reg;
            reg [31:0] dur_reg;
            reg [31:0] count_reg;
            reg [31:0] count_next;
            reg [31:0] capt_reg;
            reg [31:0] capt_next;
            reg [4:0] state_reg;
            reg [4:0] state_next;
            reg begin_reg;
            reg begin_next;
            reg finish_reg;
            reg finish_next;
            reg wrap_reg;
            reg wrap_next;
            wire restart;
            wire cnt_hit;
            wire trig_hit;
            wire clr_hit;
            wire [31:0] count_inc;

            // selected source, off forces no hit whatever the mode
            assign cnt_hit = (cnt_src_reg != `DECT_SRC_OFF) &&
                qualify(src_vec[cnt_src_reg], src_prev_reg[cnt_src_reg],
                        cnt_qual_reg,
                        PULSE_MASK[cnt_src_reg]);
            assign trig_hit = (trig_src_reg != `DECT_SRC_OFF) &&
                qualify(src_vec[trig_src_reg], src_prev_reg[trig_src_reg],
                        trig_qual_reg,
                        PULSE_MASK[trig_src_reg]);
            assign clr_hit = (clr_src_reg != `DECT_SRC_OFF) &&
                qualify(src_vec[clr_src_reg], src_prev_reg[clr_src_reg],
                        clr_qual_reg,
                        PULSE_MASK[clr_src_reg]);
            assign count_inc = count_reg + 32'h0000_0001;
            // any configuration write to this unit starts it afresh
            assign restart = mine && (wr_count_src || wr_trig_src ||
                wr_clear_src || wr_delay || wr_duration);

            // configuration writes for the selected unit
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    cnt_src_reg <= `DECT_SRC_OFF;
                    cnt_qual_reg <= `DECT_QUAL_RST;
                    trig_src_reg <= `DECT_SRC_OFF;
                    trig_qual_reg <= `DECT_QUAL_RST;
                    clr_src_reg <= `DECT_SRC_OFF;
                    clr_qual_reg <= `DECT_QUAL_RST;
                    delay_reg <= `DECT_DELAY_RST;
                    dur_reg <= `DECT_DURATION_RST;
                end else if (mine) begin
                    if (wr_count_src) begin
                        cnt_src_reg <= wsrc;
                        cnt_qual_reg <= wqual;
                    end
                    if (wr_trig_src) begin
                        trig_src_reg <= wsrc;
                        trig_qual_reg <= wqual;
                        if (wsrc != `DECT_SRC_OFF) begin
                            clr_src_reg <= `DECT_SRC_OFF;
                        end
                    end
                    if (wr_clear_src) begin
                        clr_src_reg <= wsrc;
                        clr_qual_reg <= wqual;
                        if (wsrc != `DECT_SRC_OFF) begin
                            trig_src_reg <= `DECT_SRC_OFF;
                        end
                    end
                    if (wr_delay) begin
                        delay_reg <= wdata_in;
                    end
                    if (wr_duration) begin
                        dur_reg <= wdata_in;
                    end
                end
            end

            // unit sequencing; a clear capture beats a software write
            always @* begin
                state_next = state_reg;
                count_next = count_reg;
                capt_next = (mine && wr_captured) ? wdata_in : capt_reg;
                begin_next = 1'b0;
                finish_next = 1'b0;
                wrap_next = 1'b0;
                if (restart) begin
                    state_next = S_IDLE;
                    count_next = 32'h0000_0000;
                end else begin
                    case (state_reg)
                        S_IDLE: begin
                            if (cnt_src_reg != `DECT_SRC_OFF) begin
                                state_next = S_ARMED;
                            end
                        end
                        S_ARMED: begin
                            if (trig_src_reg == `DECT_SRC_OFF || trig_hit) begin
                                state_next = S_RUNNING;
                            end
                        end
                        S_RUNNING: begin
                            if (clr_hit) begin
                                capt_next = count_reg;
                                count_next = 32'h0000_0000;
                                state_next = S_ARMED;
                            end else if (cnt_hit) begin
                                if (count_reg == CNT_MAX) begin
                                    count_next = 32'h0000_0000;
                                    state_next = S_WRAPPED;
                                    wrap_next = 1'b1;
                                end else begin
                                    count_next = count_inc;
                                    if (count_inc == delay_reg) begin
                                        begin_next = 1'b1;
                                    end
                                    if (count_inc == dur_reg) begin
                                        finish_next = 1'b1;
                                        state_next = S_DONE;
                                    end
                                end
                            end
                        end
                        S_DONE, S_WRAPPED: begin
                            if (clr_hit) begin
                                capt_next = count_reg;
                                count_next = 32'h0000_0000;
                                state_next = S_ARMED;
                            end
                        end
                        default: begin
                            state_next = S_IDLE;
                        end
                    endcase
                end
            end

            // unit state flops; events last exactly one clock
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    state_reg <= S_IDLE;
                    count_reg <= 32'h0000_0000;
                    capt_reg <= 32'h0000_0000;
                    begin_reg <= 1'b0;
                    finish_reg <= 1'b0;
                    wrap_reg <= 1'b0;
                end else begin
                    state_reg <= state_next;
                    count_reg <= count_next;
                    capt_reg <= capt_next;
                    begin_reg <= begin_next;
                    finish_reg <= finish_next;
                    wrap_reg <= wrap_next;
                end
            end

            // readback and event fan-out
            assign begin_w[gi] = begin_reg;
            assign finish_w[gi] = finish_reg;
            assign live_w[gi] = count_reg;
            assign capt_w[gi] = capt_reg;
            assign delay_w[gi] = delay_reg;
            assign dur_w[gi] = dur_reg;
            assign csrc_w[gi] = {cnt_qual_reg, 3'h0, cnt_src_reg};
            assign tsrc_w[gi] = {trig_qual_reg, 3'h0, trig_src_reg};
            assign rsrc_w[gi] = {clr_qual_reg, 3'h0, clr_src_reg};
            assign st_w[gi] = state_code(state_reg);
            assign ev_set[2 * gi] = begin_reg;
            assign ev_set[2 * gi + 1] = finish_reg;
            assign ev_set[`DECT_IRQ_WRAP_LSB + gi] = wrap_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // register port and interrupt
    // ------------------------------------------------------------------
    reg [31:0] rdata_reg;
    reg [31:0] rdata_next;
    reg [5:0] irq_stat_reg;
    reg [5:0] irq_mask_reg;
    reg irq_reg;
    wire [5:0] irq_stat_next;
    wire rd_stat = rd_en_in && (addr_in == `DECT_A_IRQ_STAT);

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_next = 32'h0000_0000;
        case (addr_in)
            `DECT_A_UNIT_SEL: rdata_next = {31'h0, unit_sel_reg};
            `DECT_A_COUNT_SRC: rdata_next = {21'h0, csrc_w[unit_sel_reg]};
            `DECT_A_TRIG_SRC: rdata_next = {21'h0, tsrc_w[unit_sel_reg]};
            `DECT_A_CLEAR_SRC: rdata_next = {21'h0, rsrc_w[unit_sel_reg]};
            `DECT_A_DELAY: rdata_next = delay_w[unit_sel_reg];
            `DECT_A_DURATION: rdata_next = dur_w[unit_sel_reg];
            `DECT_A_LIVE: rdata_next = live_w[unit_sel_reg];
            `DECT_A_CAPTURED: rdata_next = capt_w[unit_sel_reg];
            `DECT_A_STATE: rdata_next = {29'h0, st_w[unit_sel_reg]};
            `DECT_A_IRQ_STAT: rdata_next = {26'h0, irq_stat_reg};
            `DECT_A_IRQ_MASK: rdata_next = {26'h0, irq_mask_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read-to-clear, but a new event in the same cycle stays set
    assign irq_stat_next = (rd_stat ? 6'h00 : irq_stat_reg) | ev_set;

    // read data lives one cycle only; irq is a registered level
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_reg <= 32'h0000_0000;
            unit_sel_reg <= 1'b0;
            irq_stat_reg <= 6'h00;
            irq_mask_reg <= 6'h00;
            irq_reg <= 1'b0;
        end else begin
            rdata_reg <= rd_en_in ? rdata_next : 32'h0000_0000;
            if (wr_en_in && addr_in == `DECT_A_UNIT_SEL) begin
                unit_sel_reg <= wdata_in[0];
            end
            if (wr_en_in && addr_in == `DECT_A_IRQ_MASK) begin
                irq_mask_reg <= wdata_in[5:0];
            end
            irq_stat_reg <= irq_stat_next;
            irq_reg <= |(irq_stat_next & irq_mask_reg);
        end
    end

    assign rdata_out = rdata_reg;
    assign irq_out = irq_reg;
    assign unit_begin_event_out = begin_w;
    assign unit_finish_event_out = finish_w;

endmodule

// ### bench/dect_monitor.sv
// port checker for the dual counter/timer, bound from the bench top
// assumes one clock domain and the register map of dect_defs.vh
`timescale 1ns/10ps
`include "dect_defs.vh"
module dect_monitor (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] addr_in,
    input wire wr_en_in,
    input wire rd_en_in,
    input wire [31:0] rdata_out,
    input wire irq_out,
    input wire [1:0] unit_begin_event_out,
    input wire [1:0] unit_finish_event_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----------------
    // register read port
    // ----------------
    a_rdata_idle: assert property (!rd_en_in |=> rdata_out == 32'h0)
        else $error("read data without a read strobe");
    a_unmapped_zero: assert property (
        rd_en_in && addr_in > 8'h28 |=> rdata_out == 32'h0)
        else $error("unmapped address read nonzero");
    a_state_code: assert property (
        rd_en_in && addr_in == `DECT_A_STATE
        |=> rdata_out[31:3] == 0 && rdata_out[2:0] <= 3'h4)
        else $error("unit state code out of range");
    a_unit_sel: assert property (
        rd_en_in && addr_in == `DECT_A_UNIT_SEL |=> rdata_out[31:1] == 0)
        else $error("unit select wider than one bit");
    a_qualify_field: assert property (
        rd_en_in && addr_in == `DECT_A_COUNT_SRC
        |=> rdata_out[31:11] == 0 && rdata_out[10:8] <= 3'h4)
        else $error("qualify field out of range");
    // ----------------
    // event outputs: one clock each, so other units see one hit
    // ----------------
    property p_single(logic s);
        s |=> !s;
    endproperty
    a_begin_u0: assert property (p_single(unit_begin_event_out[0]))
        else $error("unit 0 begin event longer than one clock");
    a_begin_u1: assert property (p_single(unit_begin_event_out[1]))
        else $error("unit 1 begin event longer than one clock");
    a_finish_u0: assert property (p_single(unit_finish_event_out[0]))
        else $error("unit 0 finish event longer than one clock");
    a_finish_u1: assert property (p_single(unit_finish_event_out[1]))
        else $error("unit 1 finish event longer than one clock");
    c_begin_u0: cover property (unit_begin_event_out[0]);
    c_finish_u0: cover property (unit_finish_event_out[0]);
    c_irq_rise: cover property ($rose(irq_out));
endmodule

// ### bench/dect_sig_model.sv
// model of the camera signals feeding the counter sources
// indexed by source code; driven just after a rising clock edge
`timescale 1ns/10ps
module dect_sig_model (
    input wire clk_in,
    output wire [3:0] line_out,
    output wire [3:0] soft_out,
    output wire [1:0] lut_out,
    output wire open_out,
    output wire close_out,
    output wire arm_out
);
    logic [18:0] sig_reg = 19'h0;
    // ----------------
    // source map, bit index equals source code
    // ----------------
    assign line_out = sig_reg[5:2];
    assign soft_out = sig_reg[9:6];
    assign lut_out = sig_reg[15:14];
    assign open_out = sig_reg[16];
    assign close_out = sig_reg[17];
    assign arm_out = sig_reg[18];
    // set one source level at the next edge
    task automatic drive(input logic [4:0] c, input logic v);
        @(posedge clk_in);
        sig_reg[c] <= v;
    endtask
    // hold v for n sampling edges, then invert it
    task automatic pulse(input logic [4:0] c, input logic v, input int n);
        drive(c, v);
        repeat (n) @(posedge clk_in);
        sig_reg[c] <= ~v;
    endtask
endmodule

// ### bench/dect_tb_top.sv
// self-checking bench for the dual counter/timer
// assumes the register map of dect_defs.vh and one 250 MHz clock
`timescale 1ns/10ps
`include "dect_defs.vh"
module dect_tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    wire [3:0] line_w;
    wire [3:0] soft_w;
    wire [1:0] lut_w;
    wire open_w;
    wire close_w;
    wire arm_w;
    wire [31:0] rdata_out;
    wire irq_out;
    wire [1:0] unit_begin_event_out;
    wire [1:0] unit_finish_event_out;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    int b0 = 0;
    int f0 = 0, e1 = 0;
    logic [31:0] rv;
    dect_top dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .line_in(line_w), .soft_output_in(soft_w), .lut_cell_out_in(lut_w),
        .shutter_open_event_in(open_w), .shutter_close_event_in(close_w),
        .frame_arm_wait_in(arm_w), .rdata_out(rdata_out),
        .irq_out(irq_out), .unit_begin_event_out(unit_begin_event_out),
        .unit_finish_event_out(unit_finish_event_out));
    dect_sig_model sig (.clk_in(clk_in), .line_out(line_w),
        .soft_out(soft_w), .lut_out(lut_w), .open_out(open_w),
        .close_out(close_w), .arm_out(arm_w));
    initial forever #2 clk_in = ~clk_in;
    // ----------------
    // event counting and hang guard
    // ----------------
    always @(posedge clk_in) begin
        cycles++;
        if (unit_begin_event_out[0] === 1'b1) b0++;
        if (unit_finish_event_out[0] === 1'b1) f0++;
        e1 += unit_begin_event_out[1] + unit_finish_event_out[1];
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // ----------------
    // register bus master
    // ----------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
        input string what);
        logic [31:0] d;
        rd(a, d);
        chk(what, d, e);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        rdchk(`DECT_A_UNIT_SEL, 32'h0, "unit_sel");
        rdchk(`DECT_A_COUNT_SRC, 32'h0000_0300, "count_src");
        rdchk(`DECT_A_DELAY, `DECT_DELAY_RST, "delay");
        rdchk(`DECT_A_STATE, 32'h0, "state idle");
        wr(`DECT_A_LIVE, 32'h5A);
        rdchk(`DECT_A_LIVE, 32'h0, "live read only");
        rdchk(8'h30, 32'h0, "unmapped");
    endtask
    // line 0 leaves its idle level for three clocks in every mode
    task automatic t_qualify();
        logic [31:0] e [5];
        e = '{32'h3, 32'h3, 32'h1, 32'h1, 32'h2};
        wr(`DECT_A_DURATION, 32'h64);
        for (int m = 0; m < 5; m++) begin
            sig.drive(5'h02, m == 0);
            wr(`DECT_A_COUNT_SRC, 32'h2 | (m << 8));
            cyc(6);
            sig.pulse(5'h02, m != 0, 3);
            cyc(3);
            rdchk(`DECT_A_LIVE, e[m], "live per mode");
        end
    endtask
    task automatic t_events();
        int bs;
        int fs;
        rd(`DECT_A_IRQ_STAT, rv);
        wr(`DECT_A_DELAY, 32'h2);
        wr(`DECT_A_DURATION, 32'h3);
        wr(`DECT_A_COUNT_SRC, 32'h10);
        cyc(6);
        bs = b0;
        fs = f0;
        repeat (2) begin
            sig.pulse(5'h10, 1'b1, 1);
            cyc(3);
        end
        chk("begin count", b0 - bs, 32'h1);
        chk("early finish", f0 - fs, 32'h0);
        rdchk(`DECT_A_STATE, 32'h2, "state running");
        sig.pulse(5'h10, 1'b1, 1);
        cyc(3);
        chk("finish count", f0 - fs, 32'h1);
        rdchk(`DECT_A_STATE, 32'h3, "state done");
        sig.pulse(5'h10, 1'b1, 1);
        cyc(3);
        rdchk(`DECT_A_LIVE, 32'h3, "live held");
        chk("irq masked", irq_out, 32'h0);
        wr(`DECT_A_IRQ_MASK, 32'h3);
        cyc(2);
        chk("irq raised", irq_out, 32'h1);
        rdchk(`DECT_A_IRQ_STAT, 32'h3, "irq status");
        cyc(2);
        chk("irq cleared", irq_out, 32'h0);
    endtask
    // unit 1: trigger gating, then clear with capture
    task automatic t_trig();
        wr(`DECT_A_UNIT_SEL, 32'h1);
        wr(`DECT_A_DURATION, 32'h3);
        wr(`DECT_A_COUNT_SRC, 32'h306);
        wr(`DECT_A_TRIG_SRC, 32'h303);
        cyc(6);
        rdchk(`DECT_A_STATE, 32'h1, "state armed");
        sig.pulse(5'h06, 1'b1, 1);
        cyc(3);
        rdchk(`DECT_A_LIVE, 32'h0, "armed ignores");
        sig.pulse(5'h03, 1'b1, 1);
        cyc(3);
        rdchk(`DECT_A_STATE, 32'h2, "triggered");
        wr(`DECT_A_CLEAR_SRC, 32'h104);
        rd(`DECT_A_TRIG_SRC, rv);
        chk("trigger dropped", {27'h0, rv[4:0]}, 32'h0);
        cyc(4);
        repeat (3) begin
            sig.pulse(5'h06, 1'b1, 1);
            cyc(1);
        end
        cyc(3);
        rdchk(`DECT_A_LIVE, 32'h3, "live unit 1");
        chk("unit 1 events", e1, 32'h2);
        sig.pulse(5'h04, 1'b1, 1);
        cyc(3);
        rdchk(`DECT_A_CAPTURED, 32'h3, "captured");
        rdchk(`DECT_A_LIVE, 32'h0, "cleared");
        wr(`DECT_A_CAPTURED, 32'h55);
        rdchk(`DECT_A_CAPTURED, 32'h55, "captured write");
        wr(`DECT_A_UNIT_SEL, 32'h0);
        rdchk(`DECT_A_DELAY, 32'h2, "unit 0 kept");
    endtask
    initial begin
        cyc(20);
        rst_in <= 1'b0;
        t_reset();
        t_qualify();
        t_events();
        t_trig();
        finish_test();
    end
endmodule
bind dect_top dect_monitor mon (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rdata_out(rdata_out), .irq_out(irq_out),
    .unit_begin_event_out(unit_begin_event_out),
    .unit_finish_event_out(unit_finish_event_out));
